// >>> design/cas_sync_regs.svh
`ifndef CAS_SYNC_REGS_SVH
`define CAS_SYNC_REGS_SVH

// ==================================================
// external (direct) register offsets
`define CAS_EXT_CHAN_PTR 8'h02
`define CAS_EXT_SLEEP 8'h03
`define CAS_EXT_PIN_CTRL 8'h04
`define CAS_EXT_SOFT_SYNC 8'h05

// ==================================================
// internal register offsets
`define CAS_INT_AGC0_CTRL 8'h0a
`define CAS_INT_AGC0_HOLD 8'h0b
`define CAS_INT_AGC1_CTRL 8'h12
`define CAS_INT_AGC1_HOLD 8'h13
`define CAS_INT_START_HOLD 8'h83

// ==================================================
// field positions
`define CAS_AGC_SINGLE_BIT 1
`define CAS_AGC_INIT_BIT 2
`define CAS_AGC_SYNC_NOW_BIT 3
`define CAS_SOFT_START_BIT 4
`define CAS_PIN_START_BIT 4

// ==================================================
// reset values
`define CAS_SLEEP_RST 8'hff
`define CAS_CTRL_RST 8'h00
`define CAS_HOLD_RST 16'h0001

// ==================================================
// timing counts, in master clock cycles
`define CAS_SOFT_EXTRA 6
`define CAS_SOFT_PIPE (`CAS_SOFT_EXTRA + 1)
`define CAS_START_END 16'h0002
`define CAS_AGC_END 16'h0000

`endif

// >>> design/cas_pkg.sv
package cas_pkg;
  typedef logic [15:0] cas_word_t;
  typedef logic [7:0] cas_byte_t;
  typedef logic [4:0] cas_ctl5_t;
endpackage

// >>> design/cas_hold_if.sv
`timescale 1ns/1ps
interface cas_hold_if;
  logic trig;
  logic [15:0] value;
  logic repeat_en;
  logic done;
  modport ctl (output trig, output value, output repeat_en, input done);
  modport cnt (input trig, input value, input repeat_en, output done);
endinterface

// >>> design/cas_holdoff.sv
`timescale 1ns/1ps
module cas_holdoff
  import cas_pkg::*;
#(
  parameter cas_word_t END_COUNT = 16'h0000
)
(
  input wire logic ref_clk,
  input wire logic rst,
  cas_hold_if.cnt hb
);
  cas_word_t cnt;
  logic running;
  wire at_end = running && (cnt == END_COUNT);
  wire short_load = hb.trig && (hb.value < END_COUNT);

  // ==================================================
  // countdown
  assign hb.done = (at_end && !hb.trig) || short_load;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cnt <= 16'h0000;
      running <= 1'b0;
    end
    else if (hb.trig)
    begin
      cnt <= hb.value; // RQ17
      running <= !short_load;
    end
    else if (at_end)
    begin
      cnt <= hb.value; // RQ4
      running <= hb.repeat_en; // RQ4
    end
    else if (running)
    begin
      cnt <= cnt - 16'h0001; // RQ1
    end
  end

  // ==================================================
  // checks
  a_restart_load: assert property (@(posedge ref_clk) disable iff (rst)
    hb.trig && !short_load |=> running && cnt == $past(hb.value)) else $error("sync did not reload"); // RQ17
  a_count_step: assert property (@(posedge ref_clk) disable iff (rst)
    running && !hb.trig && !at_end |=> cnt == $past(cnt) - 16'h0001) else $error("count did not step"); // RQ1
  a_repeat_reload: assert property (@(posedge ref_clk) disable iff (rst)
    at_end && !hb.trig && hb.repeat_en |=> running && cnt == $past(hb.value)) else $error("no reload"); // RQ4
  a_single_stop: assert property (@(posedge ref_clk) disable iff (rst)
    at_end && !hb.trig && !hb.repeat_en |=> !running ##1 !hb.done) else $error("single sync repeated"); // RQ4
  c_repeat_seen: cover property (@(posedge ref_clk) disable iff (rst) at_end && hb.repeat_en);
endmodule

// >>> design/cas_sync_holdoff.sv
// Contract
// RQ1 - leaving sleep loads agc holdoff, counts down each clock, update starts at zero
// RQ2 - sync-now bit 3 restarts agc holdoff and updates at zero
// RQ3 - init bit 2 clears the agc accumulator with each sync update
// RQ4 - single-sync bit 1 clear repeats the countdown; set lets only first sync count
// RQ5 - first agc of a group at 0x0a-0x11, second at 0x12-0x19
// RQ6 - four sync pins reach all eight channels and four agcs together
// RQ7 - soft syncs banked by chip select, low group vs high group, at 0x5
// RQ8 - reset puts every channel to sleep
// RQ9 - sleep bits at 0x3 hold channel asleep high, run it low
// RQ10 - host programs asleep channel, holdoff 1, then clears sleep for plain start
// RQ11 - start and sync bits at 0x5 run holdoff; at one the channel wakes
// RQ12 - soft start: acknowledge rise to oscillator run is holdoff plus six
// RQ13 - host loads start holdoff above 1 and below maximum before syncing
// RQ14 - host syncs the two groups separately and allows for their skew
// RQ15 - pin start needs start-on-pin and pin enable at 0x4; pin high starts countdown
// RQ16 - pin start: pin rise to oscillator run is holdoff plus three
// RQ17 - a sync during a running countdown reloads and restarts it
`timescale 1ns/1ps
`include "cas_sync_regs.svh"
module cas_sync_holdoff
  import cas_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic select_low_group_n,
  input wire logic select_high_group_n,
  input wire logic up_wr,
  input wire logic up_rd,
  input wire logic up_ext,
  input wire logic [7:0] up_addr,
  input wire logic [15:0] up_wdata,
  input wire logic [3:0] sync_pin,
  output logic [15:0] up_rdata,
  output logic transfer_acknowledge,
  output logic [7:0] tuning_oscillator_run,
  output logic [3:0] agc_update,
  output logic [3:0] agc_clear_accum
);
  localparam int SOFT_PIPE = `CAS_SOFT_PIPE;

  cas_byte_t sleep;
  cas_byte_t next_sleep;
  logic [1:0][1:0] chan_ptr;
  logic [1:0][4:0] pin_ctrl;
  logic [1:0][4:0] soft_reg;
  cas_word_t start_hold [8];
  cas_byte_t agc_ctrl [4];
  cas_word_t agc_hold [4];
  logic [3:0] agc_armed;
  logic [SOFT_PIPE-1:0][7:0] soft_pipe;
  logic [3:0] pin_s1, pin_s2, pin_s3, pin_lvl;
  logic [7:0] start_done;
  logic [3:0] agc_done;
  logic [3:0] agc_trig;

  cas_hold_if start_hb [8] ();
  cas_hold_if agc_hb [4] ();

  function automatic logic hit(input logic ext, input logic [7:0] a, input logic want_ext, input logic [7:0] want);
    hit = (ext == want_ext) && (a == want);
  endfunction

  // ==================================================
  // microport decode
  wire sel_lo = !select_low_group_n && select_high_group_n;
  wire sel_hi = select_low_group_n && !select_high_group_n;
  wire acc = (sel_lo || sel_hi) && (up_wr || up_rd);
  wire wr = acc && up_wr;
  wire grp = sel_hi; // RQ7
  wire [2:0] ch_idx = {grp, chan_ptr[grp]};
  wire w_ptr = wr && hit(up_ext, up_addr, 1'b1, `CAS_EXT_CHAN_PTR);
  wire w_sleep = wr && hit(up_ext, up_addr, 1'b1, `CAS_EXT_SLEEP);
  wire w_pin = wr && hit(up_ext, up_addr, 1'b1, `CAS_EXT_PIN_CTRL);
  wire w_soft = wr && hit(up_ext, up_addr, 1'b1, `CAS_EXT_SOFT_SYNC);
  wire w_start = wr && hit(up_ext, up_addr, 1'b0, `CAS_INT_START_HOLD);
  wire w_ctrl0 = wr && hit(up_ext, up_addr, 1'b0, `CAS_INT_AGC0_CTRL); // RQ5
  wire w_ctrl1 = wr && hit(up_ext, up_addr, 1'b0, `CAS_INT_AGC1_CTRL); // RQ5
  wire w_hold0 = wr && hit(up_ext, up_addr, 1'b0, `CAS_INT_AGC0_HOLD);
  wire w_hold1 = wr && hit(up_ext, up_addr, 1'b0, `CAS_INT_AGC1_HOLD);
  wire soft_go = w_soft && up_wdata[`CAS_SOFT_START_BIT]; // RQ11
  wire [7:0] soft_now = soft_go ? (grp ? {up_wdata[3:0], 4'h0} : {4'h0, up_wdata[3:0]}) : 8'h00; // RQ7
  wire [3:0] ctrl_wr = {w_ctrl1 && grp, w_ctrl0 && grp, w_ctrl1 && !grp, w_ctrl0 && !grp};
  wire [3:0] hold_wr = {w_hold1 && grp, w_hold0 && grp, w_hold1 && !grp, w_hold0 && !grp};

  // ==================================================
  // sync pins
  wire [3:0] pin_rise = pin_s2 & pin_s3 & ~pin_lvl;
  wire [1:0] pin_hit = {|(pin_ctrl[1][3:0] & pin_rise), |(pin_ctrl[0][3:0] & pin_rise)}; // RQ6
  wire [1:0] pin_start = {pin_hit[1] && pin_ctrl[1][`CAS_PIN_START_BIT],
                          pin_hit[0] && pin_ctrl[0][`CAS_PIN_START_BIT]}; // RQ15
  wire [7:0] start_trig = (soft_pipe[SOFT_PIPE-1] | {{4{pin_start[1]}}, {4{pin_start[0]}}}) & sleep; // RQ16
  wire [1:0] wake = {|(sleep[7:4] & ~next_sleep[7:4]), |(sleep[3:0] & ~next_sleep[3:0])};

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
      pin_s3 <= 4'h0;
      pin_lvl <= 4'h0;
    end
    else
    begin
      pin_s1 <= sync_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_lvl <= (pin_s2 & pin_s3) | (pin_lvl & (pin_s2 | pin_s3));
    end
  end

  // ==================================================
  // holdoff counters
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_start
      assign start_hb[gi].trig = start_trig[gi]; // RQ11
      assign start_hb[gi].value = start_hold[gi];
      assign start_hb[gi].repeat_en = 1'b0;
      assign start_done[gi] = start_hb[gi].done;
      cas_holdoff #(.END_COUNT(`CAS_START_END)) u_start (.ref_clk(ref_clk), .rst(rst), .hb(start_hb[gi]));
    end
    for (gi = 0; gi < 4; gi++)
    begin : g_agc
      wire single = agc_ctrl[gi][`CAS_AGC_SINGLE_BIT];
      wire ev = pin_hit[gi/2] || wake[gi/2]; // RQ1
      assign agc_trig[gi] = (ctrl_wr[gi] && up_wdata[`CAS_AGC_SYNC_NOW_BIT]) || (ev && (!single || agc_armed[gi])); // RQ2
      assign agc_hb[gi].trig = agc_trig[gi];
      assign agc_hb[gi].value = agc_hold[gi];
      assign agc_hb[gi].repeat_en = !single; // RQ4
      assign agc_done[gi] = agc_hb[gi].done;
      cas_holdoff #(.END_COUNT(`CAS_AGC_END)) u_agc (.ref_clk(ref_clk), .rst(rst), .hb(agc_hb[gi]));
    end
  endgenerate

  // ==================================================
  // sleep and run state
  always_comb
  begin
    next_sleep = sleep;
    if (w_sleep && grp)
      next_sleep[7:4] = up_wdata[3:0]; // RQ9
    if (w_sleep && !grp)
      next_sleep[3:0] = up_wdata[3:0]; // RQ9
    next_sleep = next_sleep & ~start_done; // RQ11
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sleep <= `CAS_SLEEP_RST; // RQ8
      tuning_oscillator_run <= 8'h00; // RQ8
      soft_pipe <= '0;
    end
    else
    begin
      sleep <= next_sleep;
      tuning_oscillator_run <= ~next_sleep;
      soft_pipe <= {soft_pipe[SOFT_PIPE-2:0], soft_now}; // RQ12
    end
  end

  // ==================================================
  // register writes
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      chan_ptr <= '0;
      pin_ctrl <= '0;
      soft_reg <= '0;
      agc_armed <= 4'hf;
      for (int i = 0; i < 8; i++)
        start_hold[i] <= `CAS_HOLD_RST;
      for (int i = 0; i < 4; i++)
      begin
        agc_ctrl[i] <= `CAS_CTRL_RST;
        agc_hold[i] <= `CAS_HOLD_RST;
      end
    end
    else
    begin
      if (w_ptr)
        chan_ptr[grp] <= up_wdata[1:0];
      if (w_pin)
        pin_ctrl[grp] <= up_wdata[4:0];
      if (w_soft)
        soft_reg[grp] <= up_wdata[4:0];
      if (w_start)
        start_hold[ch_idx] <= up_wdata;
      for (int i = 0; i < 4; i++)
      begin
        if (ctrl_wr[i])
          agc_ctrl[i] <= up_wdata[7:0];
        if (hold_wr[i])
          agc_hold[i] <= up_wdata;
        if (ctrl_wr[i])
          agc_armed[i] <= !(up_wdata[`CAS_AGC_SYNC_NOW_BIT] && up_wdata[`CAS_AGC_SINGLE_BIT]);
        else if (agc_trig[i] && agc_ctrl[i][`CAS_AGC_SINGLE_BIT])
          agc_armed[i] <= 1'b0; // RQ4
      end
    end
  end

  // ==================================================
  // read data, acknowledge and agc outputs
  wire [1:0] ab = {grp, 1'b0};
  wire [15:0] rd_mux =
    hit(up_ext, up_addr, 1'b1, `CAS_EXT_CHAN_PTR) ? {14'h0000, chan_ptr[grp]} :
    hit(up_ext, up_addr, 1'b1, `CAS_EXT_SLEEP) ? {12'h000, grp ? sleep[7:4] : sleep[3:0]} :
    hit(up_ext, up_addr, 1'b1, `CAS_EXT_PIN_CTRL) ? {11'h000, pin_ctrl[grp]} :
    hit(up_ext, up_addr, 1'b1, `CAS_EXT_SOFT_SYNC) ? {11'h000, soft_reg[grp]} :
    hit(up_ext, up_addr, 1'b0, `CAS_INT_START_HOLD) ? start_hold[ch_idx] :
    hit(up_ext, up_addr, 1'b0, `CAS_INT_AGC0_CTRL) ? {8'h00, agc_ctrl[ab]} :
    hit(up_ext, up_addr, 1'b0, `CAS_INT_AGC1_CTRL) ? {8'h00, agc_ctrl[ab + 2'b01]} :
    hit(up_ext, up_addr, 1'b0, `CAS_INT_AGC0_HOLD) ? agc_hold[ab] :
    hit(up_ext, up_addr, 1'b0, `CAS_INT_AGC1_HOLD) ? agc_hold[ab + 2'b01] : 16'h0000;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      up_rdata <= 16'h0000;
      transfer_acknowledge <= 1'b0;
      agc_update <= 4'h0;
      agc_clear_accum <= 4'h0;
    end
    else
    begin
      up_rdata <= (acc && up_rd) ? rd_mux : up_rdata;
      transfer_acknowledge <= acc;
      agc_update <= agc_done; // RQ2
      for (int i = 0; i < 4; i++)
        agc_clear_accum[i] <= agc_done[i] && agc_ctrl[i][`CAS_AGC_INIT_BIT]; // RQ3
    end
  end

  // ==================================================
  // checks
  a_reset_sleep: assert property (@(posedge ref_clk)
    rst |=> sleep == 8'hff && tuning_oscillator_run == 8'h00) else $error("reset left a channel awake"); // RQ8
  a_soft_delay: assert property (@(posedge ref_clk) disable iff (rst)
    soft_now[0] |-> ##7 soft_pipe[SOFT_PIPE-1][0]) else $error("soft sync delay wrong"); // RQ12
  a_start_wake: assert property (@(posedge ref_clk) disable iff (rst)
    start_done[0] |=> !sleep[0] && tuning_oscillator_run[0]) else $error("channel did not wake"); // RQ11
  a_pin_start: assert property (@(posedge ref_clk) disable iff (rst)
    pin_rise[1] && pin_ctrl[1][4] && pin_ctrl[1][1] && sleep[4] |-> start_trig[4]) else $error("pin start lost"); // RQ15
  a_clear_with: assert property (@(posedge ref_clk) disable iff (rst)
    agc_clear_accum[0] |-> agc_update[0] && $past(agc_ctrl[0][2])) else $error("clear without update"); // RQ3
  a_bank_low: assert property (@(posedge ref_clk) disable iff (rst)
    soft_go && !grp |-> soft_now[7:4] == 4'h0) else $error("low bank reached high group"); // RQ7
  c_soft_start: cover property (@(posedge ref_clk) disable iff (rst) soft_go ##[1:300] start_done[0]);
  c_pin_start: cover property (@(posedge ref_clk) disable iff (rst) pin_start[1] ##[1:300] start_done[4]);
  c_agc_update: cover property (@(posedge ref_clk) disable iff (rst) agc_clear_accum[0]);
endmodule

// >>> dv/cas_sync_src.sv
`timescale 1ns/1ps
// ==================================================
// sync source model, drives the shared sync pins
module cas_sync_src
(
  input wire logic ref_clk,
  output logic [3:0] sync_pin
);
  initial sync_pin = 4'h0;
  // raise one pin just after an edge and hold it
  task automatic fire(input int idx);
    @(posedge ref_clk);
    #1 sync_pin[idx] = 1'b1;
  endtask
  task automatic drop(input int idx);
    @(posedge ref_clk);
    #1 sync_pin[idx] = 1'b0;
  endtask
endmodule

// >>> dv/cas_sync_holdoff_tb.sv
`timescale 1ns/1ps
`include "cas_sync_regs.svh"
module cas_sync_holdoff_tb
  import cas_pkg::*;
;
  typedef struct packed {logic [1:0] sel_n; logic wr; logic ext; cas_byte_t addr; cas_word_t wdata;
    cas_word_t exp; logic ack;} cas_row_t;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] sel_n = 2'b11;
  logic up_wr = 1'b0;
  logic up_rd = 1'b0;
  logic up_ext = 1'b0;
  cas_byte_t up_addr = 8'h00;
  cas_word_t up_wdata = 16'h0000;
  logic [3:0] sync_pin;
  cas_word_t up_rdata;
  logic transfer_acknowledge;
  cas_byte_t run;
  logic [3:0] agc_update;
  logic [3:0] agc_clear_accum;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  int n;
  // ==================================================
  // ordinary accesses: selects, write, space, address, data, read value, ack
  cas_row_t rows [14] = '{
    '{2'b10, 1'b0, 1'b1, 8'h03, 16'h0000, 16'h000f, 1'b1},
    '{2'b10, 1'b0, 1'b0, 8'h0b, 16'h0000, 16'h0001, 1'b1},
    '{2'b10, 1'b1, 1'b0, 8'h0b, 16'h0005, 16'h0000, 1'b1},
    '{2'b10, 1'b0, 1'b0, 8'h0b, 16'h0000, 16'h0005, 1'b1},
    '{2'b01, 1'b1, 1'b0, 8'h13, 16'h0004, 16'h0000, 1'b1},
    '{2'b01, 1'b0, 1'b0, 8'h13, 16'h0000, 16'h0004, 1'b1},
    '{2'b10, 1'b1, 1'b0, 8'h83, 16'h0003, 16'h0000, 1'b1},
    '{2'b01, 1'b1, 1'b0, 8'h83, 16'h0004, 16'h0000, 1'b1},
    '{2'b10, 1'b0, 1'b0, 8'h83, 16'h0000, 16'h0003, 1'b1},
    '{2'b10, 1'b1, 1'b0, 8'h0c, 16'h1234, 16'h0000, 1'b1},
    '{2'b10, 1'b0, 1'b0, 8'h0c, 16'h0000, 16'h0000, 1'b1},
    '{2'b10, 1'b0, 1'b0, 8'h0a, 16'h0000, 16'h0000, 1'b1},
    '{2'b00, 1'b1, 1'b0, 8'h0b, 16'h0009, 16'h0000, 1'b0},
    '{2'b10, 1'b0, 1'b0, 8'h0b, 16'h0000, 16'h0005, 1'b1}};

  cas_sync_holdoff u_cas_sync_holdoff (.ref_clk(ref_clk), .rst(rst), .select_low_group_n(sel_n[0]),
    .select_high_group_n(sel_n[1]), .up_wr(up_wr), .up_rd(up_rd), .up_ext(up_ext), .up_addr(up_addr),
    .up_wdata(up_wdata), .sync_pin(sync_pin), .up_rdata(up_rdata),
    .transfer_acknowledge(transfer_acknowledge), .tuning_oscillator_run(run), .agc_update(agc_update),
    .agc_clear_accum(agc_clear_accum));
  cas_sync_src u_cas_sync_src (.ref_clk(ref_clk), .sync_pin(sync_pin));

  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      wrap_up();
    end
  end
  // ==================================================
  // compare and bus tasks
  task automatic chk(input cas_word_t got, input cas_word_t exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_n(input int got, input int exp);
    check_count++;
    if (got != exp)
    begin
      err_count++;
      $display("Error at %0t: count %h expected %h", $time, got, exp);
    end
  endtask
  // one access cycle; returns in the acknowledge cycle
  task automatic acc(input logic [1:0] s, input logic w, input logic e, input cas_byte_t a, input cas_word_t d);
    @(posedge ref_clk);
    #1 sel_n = s;
    up_wr = w;
    up_rd = ~w;
    up_ext = e;
    up_addr = a;
    up_wdata = d;
    @(posedge ref_clk);
    #1 sel_n = 2'b11;
    up_wr = 1'b0;
    up_rd = 1'b0;
  endtask
  // edges until a run bit (sel 0) or an update bit (sel 1) is high, 100 at most
  task automatic wait_hi(input logic sel, input int b, output int cnt);
    cnt = 0;
    do
    begin
      @(posedge ref_clk);
      #1 cnt++;
    end while (((sel ? agc_update[b] : run[b]) !== 1'b1) && cnt < 100);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==================================================
  // main sequence
  initial
  begin
    repeat (3) @(posedge ref_clk);
    #1 rst = 1'b0;
    chk(16'(run), 16'h0000);
    chk(16'(agc_update), 16'h0000);
    foreach (rows[i])
    begin
      acc(rows[i].sel_n, rows[i].wr, rows[i].ext, rows[i].addr, rows[i].wdata);
      chk(16'(transfer_acknowledge), 16'(rows[i].ack));
      if (!rows[i].wr)
        chk(up_rdata, rows[i].exp);
    end
    acc(2'b10, 1'b1, 1'b0, `CAS_INT_AGC0_CTRL, 16'h000e);
    wait_hi(1'b1, 0, n);
    chk_n(n, 6);
    chk(16'(agc_clear_accum), 16'h0001);
    wait_hi(1'b1, 0, n);
    chk_n(n, 100);
    acc(2'b01, 1'b1, 1'b0, `CAS_INT_AGC1_CTRL, 16'h0008);
    wait_hi(1'b1, 3, n);
    chk_n(n, 5);
    chk(16'(agc_clear_accum), 16'h0000);
    wait_hi(1'b1, 3, n);
    chk_n(n, 5);
    acc(2'b01, 1'b1, 1'b0, `CAS_INT_AGC1_CTRL, 16'h0008);
    wait_hi(1'b1, 3, n);
    chk_n(n, 5);
    acc(2'b01, 1'b1, 1'b0, `CAS_INT_AGC1_CTRL, 16'h0002);
    acc(2'b10, 1'b1, 1'b1, `CAS_EXT_SOFT_SYNC, 16'h0011);
    wait_hi(1'b0, 0, n);
    chk_n(n, 9);
    chk(16'(run), 16'h0001);
    wait_hi(1'b1, 1, n);
    chk_n(n, 2);
    acc(2'b01, 1'b1, 1'b1, `CAS_EXT_PIN_CTRL, 16'h0012);
    u_cas_sync_src.fire(1);
    wait_hi(1'b0, 4, n);
    chk_n(n, 7);
    u_cas_sync_src.drop(1);
    repeat (4) @(posedge ref_clk);
    #1 chk(16'(run), 16'h00f1);
    acc(2'b10, 1'b1, 1'b1, `CAS_EXT_SLEEP, 16'h00fc);
    chk(16'(run), 16'h00f3);
    acc(2'b10, 1'b1, 1'b1, `CAS_EXT_SLEEP, 16'h00ff);
    chk(16'(run), 16'h00f0);
    acc(2'b00, 1'b1, 1'b1, `CAS_EXT_SLEEP, 16'h0000);
    chk(16'(run), 16'h00f0);
    @(posedge ref_clk);
    #1 rst = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 rst = 1'b0;
    chk(16'(run), 16'h0000);
    wrap_up();
  end
endmodule
